// ---- rtl/reset_seq_defines.svh ----
// Constants for the reset and exception entry sequencer.
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_NS        10
`define RELEASE_CYCLES       8192
`define MIN_RESET_CYCLES     10
`define CNT_W                14

// ==========================================================================
// Vector fetch and flags
// ==========================================================================
`define RESET_VECTOR_ADDR    16'h0000
`define RESET_VECTOR_ADDR_HI 16'h0001
`define IMASK_BIT            7
`define FLAGS_RESET          8'h80
`define PC_RESET             16'h0000

`endif

// ---- rtl/reset_seq_pkg.sv ----
// Types shared by the reset and exception entry sequencer.
package reset_seq_pkg;

	// ======================================================================
	// Sequencer states, Gray coded along the usual path
	// ======================================================================
	typedef enum logic [2:0] {
		ST_RESET   = 3'b000,
		ST_WAIT_MD = 3'b001,
		ST_COUNT   = 3'b011,
		ST_FETCH_H = 3'b010,
		ST_FETCH_L = 3'b110,
		ST_FIRST   = 3'b111,
		ST_RUN     = 3'b101,
		ST_EXC     = 3'b100
	} seq_state_e;

	// ======================================================================
	// Memory read request toward program memory
	// ======================================================================
	typedef struct packed {
		logic        req;
		logic [15:0] addr;
	} mem_req_s;

	// ======================================================================
	// CPU side status from the core
	// ======================================================================
	typedef struct packed {
		logic insn_done;
		logic exc_done;
	} cpu_stat_s;

endpackage : reset_seq_pkg

// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter.
module pin_sync
	import reset_seq_pkg::*;
(
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic pin_in,
	input  wire logic init_in,
	output logic      level_out
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// ======================================================================
	// Sync chain; the first stage feeds only the second.
	// ======================================================================
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts only once stages two and three agree.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			level_out <= 1'b0;
		end else if (init_in) begin
			level_out <= s3_q;
		end else if (s2_q == s3_q) begin
			level_out <= s3_q;
		end
	end

endmodule : pin_sync

// ---- rtl/release_counter.sv ----
// Down counter that times the release after the boot select pin rises.
`include "reset_seq_defines.svh"
module release_counter
	import reset_seq_pkg::*;
(
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic start_in,
	input  wire logic abort_in,
	output logic      done_out
);

	logic [`CNT_W-1:0] cnt_q;
	logic              run_q;

	// ======================================================================
	// Counts the full release period, then pulses done for one cycle.
	// ======================================================================
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q    <= '0;
			run_q    <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (abort_in) begin
				run_q <= 1'b0;
				cnt_q <= '0;
			end else if (start_in && !run_q) begin
				run_q <= 1'b1;
				cnt_q <= `CNT_W'(`RELEASE_CYCLES - 1);
			end else if (run_q) begin
				if (cnt_q == '0) begin
					run_q    <= 1'b0;
					done_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end

endmodule : release_counter

// ---- rtl/reset_exception_sequencer.sv ----
// Reset and exception entry sequencer of the small microcontroller core.
`include "reset_seq_defines.svh"
module reset_exception_sequencer
	import reset_seq_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic        chip_clear_pin_n_in,
	input  wire logic        boot_select_pin_in,
	input  wire logic [7:0]  mem_rdata_in,
	input  wire logic        mem_rvalid_in,
	input  wire cpu_stat_s   cpu_stat_in,
	input  wire logic        irq_pending_in,
	input  wire logic        imask_clear_in,
	output mem_req_s         mem_req_out,
	output logic [15:0]      pc_out,
	output logic             pc_valid_out,
	output logic             cpu_hold_out,
	output logic             periph_reset_out,
	output logic [7:0]       cond_flags_out,
	output logic             irq_accept_out
);

	seq_state_e  state_q;
	seq_state_e  state_d;
	logic        clr_n_lvl;
	logic        boot_lvl;
	logic        boot_prev_q;
	logic        boot_rise;
	logic        count_done;
	logic        clr_low;
	logic [7:0]  vec_hi_q;
	logic        sync_init_q;

	// ======================================================================
	// Timing notes
	// ======================================================================
	// Both pins pass a three-stage synchroniser and an agreement filter, so
	// a pin change reaches the state machine four clock edges after it is
	// first sampled. A chip clear pulse shorter than that may be missed.
	// That is acceptable because the external source must hold the pin low
	// for at least ten clock cycles while the device is running.
	// The release count is therefore timed from the filtered boot select
	// edge, not from the raw pin. This adds the filter delay to the count,
	// which trades a few cycles of extra wait for immunity to pin bounce.
	// The hold, reset, request and accept outputs are registered from the next state, so each
	// changes on the same edge as the state register it reflects.

	// ======================================================================
	// State decoding shared by the output registers
	// ======================================================================
	// The core must not run before the vector word is loaded, or it would
	// start from a stale program counter.
	function automatic logic core_halted(input seq_state_e s);
		core_halted = (s == ST_RESET) || (s == ST_WAIT_MD) || (s == ST_COUNT)
		              || (s == ST_FETCH_H) || (s == ST_FETCH_L);
	endfunction : core_halted

	// Peripherals leave reset when the vector fetch starts, two phases ahead
	// of the core, so their registers are settled before the first fetch.
	function automatic logic periph_in_reset(input seq_state_e s);
		periph_in_reset = (s == ST_RESET) || (s == ST_WAIT_MD) || (s == ST_COUNT);
	endfunction : periph_in_reset

	// The two vector fetch phases; the mask bit is pinned high through them.
	function automatic logic fetching(input seq_state_e s);
		fetching = (s == ST_FETCH_H) || (s == ST_FETCH_L);
	endfunction : fetching

	// ======================================================================
	// Pin synchronisers
	// ======================================================================
	pin_sync u_clr_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.pin_in     (chip_clear_pin_n_in),
		.init_in    (sync_init_q),
		.level_out  (clr_n_lvl)
	);

	pin_sync u_boot_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.pin_in     (boot_select_pin_in),
		.init_in    (sync_init_q),
		.level_out  (boot_lvl)
	);

	// Makes the filters load the third stage, still at its reset value, in the first cycle after reset.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_init_q <= 1'b1;
		end else begin
			sync_init_q <= 1'b0;
		end
	end

	assign clr_low = !clr_n_lvl || sync_init_q;

	// ======================================================================
	// Boot select edge detection on the filtered level
	// ======================================================================
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			boot_prev_q <= 1'b1;
		end else begin
			boot_prev_q <= boot_lvl;
		end
	end

	assign boot_rise = boot_lvl && !boot_prev_q;

	// ======================================================================
	// Release counter
	// ======================================================================
	// The count is only started in the wait state and is killed by any new
	// chip clear, so a glitchy pin cannot shorten the release.
	release_counter u_release (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.start_in   (state_q == ST_WAIT_MD && boot_rise && !clr_low),
		.abort_in   (clr_low),
		.done_out   (count_done)
	);

	// ======================================================================
	// Next state
	// ======================================================================
	always_comb begin
		state_d = state_q;
		if (clr_low) begin
			state_d = ST_RESET;
		end else begin
			unique case (state_q)
				ST_RESET: begin
					if (boot_lvl) begin
						state_d = ST_FETCH_H;
					end else begin
						state_d = ST_WAIT_MD;
					end
				end
				ST_WAIT_MD: begin
					if (boot_rise) begin
						state_d = ST_COUNT;
					end
				end
				ST_COUNT: begin
					if (count_done) begin
						state_d = ST_FETCH_H;
					end
				end
				ST_FETCH_H: begin
					if (mem_rvalid_in) begin
						state_d = ST_FETCH_L;
					end
				end
				ST_FETCH_L: begin
					if (mem_rvalid_in) begin
						state_d = ST_FIRST;
					end
				end
				ST_FIRST: begin
					if (cpu_stat_in.insn_done) begin
						state_d = ST_RUN;
					end
				end
				ST_RUN: begin
					if (irq_pending_in && !cond_flags_out[`IMASK_BIT]
					    && cpu_stat_in.insn_done) begin
						state_d = ST_EXC;
					end
				end
				ST_EXC: begin
					if (cpu_stat_in.exc_done) begin
						state_d = ST_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ======================================================================
	// Hold and peripheral reset outputs
	// ======================================================================
	// The core stays halted until the vector word has been loaded.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cpu_hold_out     <= 1'b1;
			periph_reset_out <= 1'b1;
		end else begin
			cpu_hold_out     <= core_halted(state_d);
			periph_reset_out <= periph_in_reset(state_d);
		end
	end

	// ======================================================================
	// Vector fetch, high byte first at the lower address
	// ======================================================================
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mem_req_out <= '0;
			vec_hi_q    <= 8'h00;
		end else begin
			mem_req_out.req  <= fetching(state_d);
			mem_req_out.addr <= (state_d == ST_FETCH_L) ? `RESET_VECTOR_ADDR_HI
			                                            : `RESET_VECTOR_ADDR;
			if (state_q == ST_FETCH_H && mem_rvalid_in && !clr_low) begin
				vec_hi_q <= mem_rdata_in;
			end
		end
	end

	// Program counter takes the vector word; valid marks fetch may begin.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pc_out       <= `PC_RESET;
			pc_valid_out <= 1'b0;
		end else if (clr_low) begin
			pc_out       <= `PC_RESET;
			pc_valid_out <= 1'b0;
		end else if (state_q == ST_FETCH_L && mem_rvalid_in) begin
			pc_out       <= {vec_hi_q, mem_rdata_in};
			pc_valid_out <= 1'b1;
		end
	end

	// ======================================================================
	// Condition flags: mask bit set by reset, cleared only by the core
	// ======================================================================
	// A clear request during reset entry is ignored, so the mask bit is
	// always one when the first instruction runs.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cond_flags_out <= `FLAGS_RESET;
		end else if (state_d == ST_RESET || fetching(state_q)) begin
			cond_flags_out[`IMASK_BIT] <= 1'b1;
		end else if (state_q == ST_EXC && state_d == ST_EXC) begin
			cond_flags_out[`IMASK_BIT] <= 1'b1;
		end else if (imask_clear_in && (state_q == ST_RUN || state_q == ST_FIRST)) begin
			cond_flags_out[`IMASK_BIT] <= 1'b0;
		end
	end

	// ======================================================================
	// Interrupt acceptance pulse
	// ======================================================================
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_accept_out <= 1'b0;
		end else begin
			irq_accept_out <= (state_q == ST_RUN) && (state_d == ST_EXC);
		end
	end

endmodule : reset_exception_sequencer

// ---- verif/reset_seq_props.sv ----
// Port checks for the reset and exception entry sequencer.
`include "reset_seq_defines.svh"
module reset_seq_props
	import reset_seq_pkg::*;
(
	input wire logic      ref_clk_in,
	input wire logic      rst_in,
	input wire logic      chip_clear_pin_n_in,
	input wire logic      boot_select_pin_in,
	input wire logic      mem_rvalid_in,
	input wire cpu_stat_s cpu_stat_in,
	input wire logic      irq_pending_in,
	input wire mem_req_s  mem_req_out,
	input wire logic      pc_valid_out,
	input wire logic      cpu_hold_out,
	input wire logic      periph_reset_out,
	input wire logic [7:0] cond_flags_out,
	input wire logic      irq_accept_out
);
	// ======================================================================
	// Checks, all in the system clock domain
	// ======================================================================
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	// Eight cycles leave room for the pin filter and the registered answer.
	AST_CLEAR_HALTS: assert property (
		!chip_clear_pin_n_in [*8] |-> cpu_hold_out && periph_reset_out)
		else $error("Core or peripherals still running under chip clear.");
	AST_FLAGS_RESET: assert property (
		periph_reset_out |-> cond_flags_out == `FLAGS_RESET)
		else $error("Flags wrong while in reset.");
	AST_VEC_HI_ADDR: assert property (
		$rose(mem_req_out.req) |-> mem_req_out.addr == `RESET_VECTOR_ADDR)
		else $error("First vector read at wrong address.");
	AST_VEC_LO_ADDR: assert property (
		mem_req_out.req && mem_rvalid_in && mem_req_out.addr == `RESET_VECTOR_ADDR
		|=> mem_req_out.req && mem_req_out.addr == `RESET_VECTOR_ADDR_HI)
		else $error("Second vector read missing.");
	AST_RUN_NO_HOLD: assert property (
		pc_valid_out |-> !cpu_hold_out && !periph_reset_out)
		else $error("Core held after program counter load.");
	AST_ACC_MASK: assert property (
		irq_accept_out |-> !$past(cond_flags_out[`IMASK_BIT]))
		else $error("Interrupt accepted while masked.");
	AST_ACC_CAUSE: assert property (
		irq_accept_out |-> $past(irq_pending_in
		&& (cpu_stat_in.insn_done || cpu_stat_in.exc_done)))
		else $error("Interrupt accepted off an instruction boundary.");
	AST_ACC_PULSE: assert property (
		irq_accept_out |=> !irq_accept_out)
		else $error("Accept pulse longer than one cycle.");
	AST_START_PINS: assert property (
		$rose(mem_req_out.req) |-> $past(boot_select_pin_in, 4)
		&& $past(chip_clear_pin_n_in, 4))
		else $error("Vector fetch started without both pins high.");

	cover property ($rose(pc_valid_out));
	cover property (irq_accept_out);
	cover property ($rose(cpu_hold_out));
endmodule : reset_seq_props

bind reset_exception_sequencer reset_seq_props props (.ref_clk_in, .rst_in,
	.chip_clear_pin_n_in, .boot_select_pin_in, .mem_rvalid_in, .cpu_stat_in,
	.irq_pending_in, .mem_req_out, .pc_valid_out, .cpu_hold_out,
	.periph_reset_out, .cond_flags_out, .irq_accept_out);

// ---- verif/vec_mem_model.sv ----
// Program memory model that answers the vector byte reads.
module vec_mem_model
	import reset_seq_pkg::*;
#(
	parameter logic [15:0] VECTOR = 16'h1234
)(
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire mem_req_s   req_in,
	input  wire logic [3:0] delay_in,
	output logic [7:0]      rdata_out,
	output logic            rvalid_out
);
	logic [3:0] wait_q;

	// One byte per request after delay_in idle cycles. Outside the valid
	// cycle the data bus walks a filler so a stale byte cannot pass.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wait_q     <= 4'h0;
			rvalid_out <= 1'b0;
			rdata_out  <= 8'h00;
		end else begin
			rvalid_out <= 1'b0;
			rdata_out  <= rdata_out + 8'h3b;
			if (!req_in.req || rvalid_out) begin
				wait_q <= 4'h0;
			end else if (wait_q != delay_in) begin
				wait_q <= wait_q + 4'h1;
			end else begin
				rvalid_out <= 1'b1;
				rdata_out  <= req_in.addr[0] ? VECTOR[7:0] : VECTOR[15:8];
			end
		end
	end
endmodule : vec_mem_model

// ---- verif/tb_top.sv ----
// Self-checking testbench of the reset and exception entry sequencer.
`include "reset_seq_defines.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
	$display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top
	import reset_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] VEC = 16'ha5c3;
	logic       ref_clk_in = 1'b0, rst_in = 1'b1, clr_n = 1'b0, boot = 1'b1;
	logic       irq_pend = 1'b0, mclr = 1'b0, rvalid, pc_valid, hold, prst, acc;
	logic [3:0] delay = 4'h0;
	logic [7:0] rdata, flags;
	logic [15:0] pc;
	cpu_stat_s  stat = '0;
	mem_req_s   req;
	int         n_errors = 0, comparisons = 0;

	always #5 ref_clk_in = ~ref_clk_in;

	reset_exception_sequencer dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.chip_clear_pin_n_in(clr_n), .boot_select_pin_in(boot), .mem_rdata_in(rdata),
		.mem_rvalid_in(rvalid), .cpu_stat_in(stat), .irq_pending_in(irq_pend),
		.imask_clear_in(mclr), .mem_req_out(req), .pc_out(pc), .pc_valid_out(pc_valid),
		.cpu_hold_out(hold), .periph_reset_out(prst), .cond_flags_out(flags),
		.irq_accept_out(acc));
	vec_mem_model #(.VECTOR(VEC)) mem (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.req_in(req), .delay_in(delay), .rdata_out(rdata), .rvalid_out(rvalid));

	// ======================================================================
	// Helpers
	// ======================================================================
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask : cyc

	// Watches n cycles and reports whether the signal was ever high.
	task watch(input int n, input bit use_req, output logic seen);
		seen = 1'b0;
		repeat (n) begin
			@(negedge ref_clk_in);
			seen = seen | (use_req ? req.req : acc);
		end
		// Return on a rising edge so the caller drives inputs there.
		@(posedge ref_clk_in);
	endtask : watch

	task wait_run(input int lim, output int n);
		n = 0;
		while (pc_valid !== 1'b1 && n < lim) begin
			@(negedge ref_clk_in);
			n++;
		end
		`CHK(pc, VEC)
		`CHK(hold, 1'b0)
		`CHK(prst, 1'b0)
		`CHK(flags[7], 1'b1)
		@(posedge ref_clk_in);
	endtask : wait_run

	task insn;
		@(posedge ref_clk_in);
		stat.insn_done <= 1'b1;
		@(posedge ref_clk_in);
		stat.insn_done <= 1'b0;
	endtask : insn

	// ======================================================================
	// Scenarios
	// ======================================================================
	task t_boot_high;
		int n;
		boot  <= 1'b1;
		clr_n <= 1'b0;
		cyc(16);
		clr_n <= 1'b1;
		wait_run(60, n);
		`CHK(n < 20, 1'b1)
	endtask : t_boot_high

	// Pending request: blocked by the first instruction first, then masked.
	task t_first_insn;
		logic s;
		irq_pend <= 1'b1;
		insn();
		watch(4, 1'b0, s);
		`CHK(s, 1'b0)
		insn();
		watch(4, 1'b0, s);
		`CHK(s, 1'b0)
		@(posedge ref_clk_in);
		mclr <= 1'b1;
		@(posedge ref_clk_in);
		mclr <= 1'b0;
		insn();
		watch(4, 1'b0, s);
		`CHK(s, 1'b1)
		// Exception under way: a further boundary must not accept again.
		insn();
		watch(4, 1'b0, s);
		`CHK(s, 1'b0)
		irq_pend <= 1'b0;
	endtask : t_first_insn

	task t_reset_running;
		int n;
		clr_n <= 1'b0;
		cyc(8);
		@(negedge ref_clk_in);
		`CHK({hold, prst, pc_valid, flags}, {3'b110, 8'h80})
		cyc(4);
		clr_n <= 1'b1;
		delay <= 4'h5;
		wait_run(80, n);
	endtask : t_reset_running

	task t_boot_low;
		int n;
		logic s;
		boot  <= 1'b0;
		clr_n <= 1'b0;
		cyc(12);
		clr_n <= 1'b1;
		watch(100, 1'b1, s);
		`CHK({s, hold}, 2'b01)
		boot <= 1'b1;
		cyc(4000);
		clr_n <= 1'b0;
		boot  <= 1'b0;
		cyc(12);
		clr_n <= 1'b1;
		watch(8300, 1'b1, s);
		`CHK(s, 1'b0)
		boot <= 1'b1;
		n = 0;
		while (req.req !== 1'b1 && n < 8400) begin
			@(negedge ref_clk_in);
			n++;
		end
		`CHK(n >= `RELEASE_CYCLES && n <= `RELEASE_CYCLES + 12, 1'b1)
		wait_run(60, n);
	endtask : t_boot_low

	// ======================================================================
	// Verdict, main sequence and watchdog
	// ======================================================================
	task test_done;
		$display("Comparisons %0d, errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	initial begin
		cyc(16);
		rst_in <= 1'b0;
		t_boot_high();
		t_first_insn();
		t_reset_running();
		t_boot_low();
		test_done();
	end

	// The whole run needs about 21000 cycles; twice that means a hang.
	initial begin
		cyc(45000);
		n_errors++;
		test_done();
	end
endmodule : tb_top
